// ### core/misc_regs_pkg.sv
// constants, types and state layouts for the board register bank
package misc_regs_pkg;

    // bus widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W  = 8;

    typedef logic [ADDR_W-1:0]       bus_addr_t;
    typedef logic [DATA_W-1:0]       bus_data_t;
    typedef logic [REG_W-1:0]        reg_byte_t;
    typedef logic [3:0][REG_W-1:0]   irq_vec_t;
    typedef logic [3:0][REG_W-1:0]   pd_slots_t;

    // register offsets on the expansion bus
    localparam bus_addr_t OFF_DISPLAY     = 12'h800;
    localparam bus_addr_t OFF_BOARD_CFG   = 12'h801;
    localparam bus_addr_t OFF_IRQ_MASK_1  = 12'h802;
    localparam bus_addr_t OFF_IRQ_MASK_2  = 12'h803;
    localparam bus_addr_t OFF_IRQ_MASK_3  = 12'h804;
    localparam bus_addr_t OFF_IRQ_MASK_4  = 12'h805;
    localparam bus_addr_t OFF_MEM_SLOT_0  = 12'h806;
    localparam bus_addr_t OFF_MEM_SLOT_1  = 12'h807;
    localparam bus_addr_t OFF_MEM_SLOT_2  = 12'h808;
    localparam bus_addr_t OFF_MEM_SLOT_3  = 12'h809;
    localparam bus_addr_t OFF_RST_CAUSE_1 = 12'h80a;
    localparam bus_addr_t OFF_MEM_IDENT   = 12'h80b;
    localparam bus_addr_t OFF_HEARTBEAT   = 12'h80c;
    localparam bus_addr_t OFF_BOARD_CTRL  = 12'h80d;
    localparam bus_addr_t OFF_RST_CAUSE_2 = 12'h80e;
    localparam bus_addr_t OFF_BCACHE_CFG  = 12'h80f;
    localparam bus_addr_t OFF_RST_CAUSE_3 = 12'h82e;

    // display register fields and values
    localparam int        DISP_CHAR_W    = 7;
    localparam int        DISP_BRIGHT_BIT = 7;
    localparam reg_byte_t DISP_RESET     = 8'hff;
    localparam logic [DISP_CHAR_W-1:0] DISP_FIRST_PRINTABLE = 7'h20;

    // board configuration fields
    localparam int CFG_RTC_CLEAR_BIT = 0;
    localparam int CFG_BOOT_BIT      = 2;
    localparam int CFG_TYPE_LSB      = 3;
    localparam int CFG_SPEED_LSB     = 5;

    // interrupt/mask group indices and wiring
    localparam int IRQ_GRP_1   = 0;
    localparam int IRQ_GRP_2   = 1;
    localparam int IRQ_GRP_3   = 2;
    localparam int IRQ_GRP_4   = 3;
    localparam int SYSRST_BIT  = 0;
    localparam int IRQ_LINES   = 4;
    localparam irq_vec_t IRQ_MASK_RESET = 32'h00000000;

    // request bits feeding each processor interrupt line, index = line
    localparam logic [3:0][31:0] IRQ_LINE_SEL = '{
        32'h0000000f,  // line 3: group 1 bits 3:0
        32'h00000030,  // line 2: group 1 bits 5:4
        32'h00000700,  // line 1: group 2 bits 2:0
        32'h03ff0000   // line 0: group 3 all, group 4 bits 1:0
    };

    localparam reg_byte_t CTRL_RESET  = 8'h00;
    localparam reg_byte_t CAUSE_RESET = 8'h00;

    typedef struct packed {
        reg_byte_t  disp;
        irq_vec_t   irq_mask;
        reg_byte_t  cause1;
        reg_byte_t  cause2;
        reg_byte_t  cause3;
        reg_byte_t  ctrl;
        bus_data_t  rdata;
        logic       rd_valid;
        logic       rtc_clear;
        logic       hb_clear;
        logic [3:0] irq;
    } bank_state_t;

    typedef struct packed {
        logic [DISP_CHAR_W-1:0] code;
        logic                   bright;
        logic                   blank;
        logic                   all_lit;
    } glyph_state_t;

endpackage : misc_regs_pkg

// ### core/char_display_drive.sv
// drive stage for the dot-matrix character display
`timescale 1ns/1ps
module char_display_drive (
    input  wire logic                                core_clk,
    input  wire logic                                rst,
    input  wire logic [misc_regs_pkg::DISP_CHAR_W-1:0] char_code,
    input  wire logic                                char_bright,
    output logic [misc_regs_pkg::DISP_CHAR_W-1:0]    glyph_code,
    output logic                                     glyph_bright,
    output logic                                     glyph_blank,
    output logic                                     all_dots_lit
);
    import misc_regs_pkg::*;

    glyph_state_t s;
    glyph_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.code = char_code;
        next_s.bright = char_bright;
        next_s.blank = (char_code < DISP_FIRST_PRINTABLE); // [RULE4]
        next_s.all_lit = 1'b0;
        if (rst) begin
            next_s.all_lit = 1'b1; // [RULE6]
            next_s.blank = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        s <= next_s;
    end

    assign glyph_code = s.code;
    assign glyph_bright = s.bright;
    assign glyph_blank = s.blank;
    assign all_dots_lit = s.all_lit;

    a_dots_in_reset: assert property (@(posedge core_clk)
        rst |=> all_dots_lit) // [RULE6]
        else $error("display not fully lit during reset");

    a_blank_low_codes: assert property (@(posedge core_clk) disable iff (rst)
        !$past(rst) |-> (glyph_blank == ($past(char_code) < 7'h20))) // [RULE4]
        else $error("blanking does not follow code range");

endmodule : char_display_drive

// ### core/module_misc_register_bank.sv
// board register bank: display, configuration, interrupt masks, slots
//
// Behaviour
// (RULE1) seventeen byte registers decoded at 0x800..0x80f and 0x82e
// (RULE2) display register low seven bits select the shown character
// (RULE3) display bit 7 set gives full brightness, clear gives normal
// (RULE4) codes 0x20..0x7f show printable glyphs, lower codes show blank
// (RULE5) after reset display shows 0x7f at full brightness
// (RULE6) while reset is held every display dot is lit
// (RULE7) configuration reads board wiring, untouched by any reset
// (RULE8) configuration write with bit 0 set clears periodic timer
// (RULE9) configuration bit 2 reports the boot selection strap
// (RULE10) configuration bits 4:3 report the io module type code
// (RULE11) configuration bits 6:5 report the processor speed code
// (RULE12) interrupt line 3 from group 1 bits 3:0 only
// (RULE13) interrupt line 2 from group 1 bits 5:4 only
// (RULE14) interrupt line 1 from group 2 bits 2:0 only
// (RULE15) line 0 from group 3 all bits and group 4 bits 1:0
// (RULE16) four memory slot registers are read-only presence-detect values
// (RULE17) slot register packs detect bits 4-1, 5, 7-6, 8 into 3:0,4,6:5,7
// (RULE18) slot bit 4 tells fast-page or fast-page with extended data out
// (RULE19) software decodes detect bits 4-1 into module geometry and refresh
// (RULE20) bus system reset feeds group 3 bit 0
// (RULE21) registers are eight bits; upper data bits read zero, writes ignore
// (RULE22) a line asserts while any selected request is pending and unmasked
`timescale 1ns/1ps
module module_misc_register_bank (
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    // expansion bus register port
    input  wire misc_regs_pkg::bus_addr_t  bus_addr,
    input  wire logic                      bus_rd,
    input  wire logic                      bus_wr,
    input  wire misc_regs_pkg::bus_data_t  bus_wdata,
    output misc_regs_pkg::bus_data_t       bus_rdata,
    output logic                           bus_rd_valid,
    // board wiring
    input  wire logic                      boot_select_strap,
    input  wire logic [1:0]                io_module_type_code,
    input  wire logic [1:0]                processor_speed_code,
    input  wire misc_regs_pkg::pd_slots_t  presence_detect,
    input  wire misc_regs_pkg::reg_byte_t  mem_module_ident_bits,
    input  wire misc_regs_pkg::reg_byte_t  backup_cache_bits,
    // interrupt sources
    input  wire misc_regs_pkg::irq_vec_t   irq_request,
    input  wire logic                      bus_sys_reset,
    output logic [3:0]                     cpu_irq,
    // side effects and control
    output logic                           rtc_timer_clear,
    output logic                           heartbeat_clear,
    output misc_regs_pkg::reg_byte_t       board_control,
    // display
    output logic [misc_regs_pkg::DISP_CHAR_W-1:0] display_char,
    output logic                           display_bright,
    output logic                           display_blank,
    output logic                           display_all_lit
);
    import misc_regs_pkg::*;

    bank_state_t s;
    bank_state_t next_s;
    irq_vec_t    pend;
    reg_byte_t   cfg_value;
    reg_byte_t   rd_value;
    logic [3:0]  line_hit;
    reg_byte_t   wbyte;

    // upper data bits are dropped on the way in
    assign wbyte = bus_wdata[REG_W-1:0]; // [RULE21]

    // request image, with the bus system reset wired into group 3
    always_comb begin
        pend = irq_request;
        pend[IRQ_GRP_3][SYSRST_BIT] = bus_sys_reset; // [RULE20]
    end

    // hardwired configuration image, no flop so no reset can touch it
    always_comb begin
        cfg_value = '0;
        cfg_value[CFG_BOOT_BIT] = boot_select_strap; // [RULE9] [RULE7]
        cfg_value[CFG_TYPE_LSB +: 2] = io_module_type_code; // [RULE10]
        cfg_value[CFG_SPEED_LSB +: 2] = processor_speed_code; // [RULE11]
    end

    // per-line request selection
    for (genvar i = 0; i < IRQ_LINES; i++) begin : g_line
        // [RULE12] [RULE13] [RULE14] [RULE15] [RULE22]
        assign line_hit[i] = |(pend & s.irq_mask & IRQ_LINE_SEL[i]);
    end

    // read multiplexer
    always_comb begin
        rd_value = '0; // unmapped offsets read zero
        case (bus_addr) // [RULE1]
            OFF_DISPLAY:     rd_value = s.disp;
            OFF_BOARD_CFG:   rd_value = cfg_value; // [RULE7]
            OFF_IRQ_MASK_1:  rd_value = pend[IRQ_GRP_1];
            OFF_IRQ_MASK_2:  rd_value = pend[IRQ_GRP_2];
            OFF_IRQ_MASK_3:  rd_value = pend[IRQ_GRP_3];
            OFF_IRQ_MASK_4:  rd_value = pend[IRQ_GRP_4];
            // slot bits already arrive as detect 8..1 -> 7..0
            OFF_MEM_SLOT_0:  rd_value = presence_detect[0]; // [RULE16] [RULE17]
            OFF_MEM_SLOT_1:  rd_value = presence_detect[1]; // [RULE16] [RULE17]
            OFF_MEM_SLOT_2:  rd_value = presence_detect[2]; // [RULE16] [RULE17]
            OFF_MEM_SLOT_3:  rd_value = presence_detect[3]; // [RULE16] [RULE18]
            OFF_RST_CAUSE_1: rd_value = s.cause1;
            OFF_MEM_IDENT:   rd_value = mem_module_ident_bits;
            OFF_HEARTBEAT:   rd_value = '0;
            OFF_BOARD_CTRL:  rd_value = s.ctrl;
            OFF_RST_CAUSE_2: rd_value = s.cause2;
            OFF_BCACHE_CFG:  rd_value = backup_cache_bits;
            OFF_RST_CAUSE_3: rd_value = s.cause3;
            default:         rd_value = '0;
        endcase
    end

    // next-state logic
    always_comb begin
        next_s = s;
        next_s.rd_valid = bus_rd;
        next_s.rtc_clear = 1'b0;
        next_s.hb_clear = 1'b0;
        next_s.irq = line_hit; // [RULE22]
        if (bus_rd) begin
            next_s.rdata = {{(DATA_W-REG_W){1'b0}}, rd_value}; // [RULE21]
        end
        if (bus_wr) begin
            case (bus_addr)
                OFF_DISPLAY: begin
                    next_s.disp = wbyte; // [RULE2] [RULE3]
                end
                OFF_BOARD_CFG: begin
                    // stored image stays; only the timer clear fires
                    next_s.rtc_clear = wbyte[CFG_RTC_CLEAR_BIT]; // [RULE8]
                end
                OFF_IRQ_MASK_1: begin
                    next_s.irq_mask[IRQ_GRP_1] = wbyte;
                end
                OFF_IRQ_MASK_2: begin
                    next_s.irq_mask[IRQ_GRP_2] = wbyte;
                end
                OFF_IRQ_MASK_3: begin
                    next_s.irq_mask[IRQ_GRP_3] = wbyte;
                end
                OFF_IRQ_MASK_4: begin
                    next_s.irq_mask[IRQ_GRP_4] = wbyte;
                end
                OFF_RST_CAUSE_1: begin
                    next_s.cause1 = wbyte;
                end
                OFF_RST_CAUSE_2: begin
                    next_s.cause2 = wbyte;
                end
                OFF_RST_CAUSE_3: begin
                    next_s.cause3 = wbyte;
                end
                OFF_HEARTBEAT: begin
                    next_s.hb_clear = 1'b1; // data independent
                end
                OFF_BOARD_CTRL: begin
                    next_s.ctrl = wbyte;
                end
                default: begin
                    next_s.disp = s.disp; // read-only or unmapped
                end
            endcase
        end
        if (rst) begin
            next_s.disp = DISP_RESET; // [RULE5]
            next_s.irq_mask = IRQ_MASK_RESET;
            next_s.cause1 = CAUSE_RESET;
            next_s.cause2 = CAUSE_RESET;
            next_s.cause3 = CAUSE_RESET;
            next_s.ctrl = CTRL_RESET;
            next_s.rdata = '0;
            next_s.rd_valid = 1'b0;
            next_s.rtc_clear = 1'b0;
            next_s.hb_clear = 1'b0;
            next_s.irq = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        s <= next_s;
    end

    char_display_drive u_display (
        .core_clk     (core_clk),
        .rst          (rst),
        .char_code    (s.disp[DISP_CHAR_W-1:0]), // [RULE2]
        .char_bright  (s.disp[DISP_BRIGHT_BIT]), // [RULE3]
        .glyph_code   (display_char),
        .glyph_bright (display_bright),
        .glyph_blank  (display_blank),
        .all_dots_lit (display_all_lit)
    );

    assign bus_rdata = s.rdata;
    assign bus_rd_valid = s.rd_valid;
    assign cpu_irq = s.irq;
    assign rtc_timer_clear = s.rtc_clear;
    assign heartbeat_clear = s.hb_clear;
    assign board_control = s.ctrl;

    // checks

    a_disp_reset_value: assert property (@(posedge core_clk) // [RULE5]
        rst ##1 !rst |-> s.disp == 8'hff && display_char == 7'h7f)
        else $error("display does not come up at 7f bright");

    a_disp_write_byte: assert property (@(posedge core_clk) // [RULE2]
        disable iff (rst)
        (bus_wr && bus_addr == 12'h800) |=>
            s.disp == $past(bus_wdata[7:0]) ##1
            (display_char == $past(bus_wdata[6:0], 2) &&
             display_bright == $past(bus_wdata[7], 2))) // [RULE3]
        else $error("display write not reflected on display");

    a_cfg_readback: assert property (@(posedge core_clk) // [RULE7]
        disable iff (rst)
        (bus_rd && bus_addr == 12'h801) |=>
            bus_rd_valid && bus_rdata == {24'h0, 1'b0,
            $past(processor_speed_code), $past(io_module_type_code),
            $past(boot_select_strap), 2'b00})
        else $error("configuration readback wrong");

    a_rtc_clear_pulse: assert property (@(posedge core_clk) // [RULE8]
        disable iff (rst)
        rtc_timer_clear == $past(bus_wr && bus_addr == 12'h801 &&
                                 bus_wdata[0]))
        else $error("timer clear pulse mismatch");

    a_irq3_source: assert property (@(posedge core_clk) // [RULE12]
        disable iff (rst)
        !$past(rst) |-> cpu_irq[3] ==
            $past(|(irq_request[0][3:0] & s.irq_mask[0][3:0])))
        else $error("line 3 does not follow group 1 low bits");

    a_irq2_source: assert property (@(posedge core_clk) // [RULE13]
        disable iff (rst)
        !$past(rst) |-> cpu_irq[2] ==
            $past(|(irq_request[0][5:4] & s.irq_mask[0][5:4])))
        else $error("line 2 does not follow group 1 bits 5:4");

    a_irq1_source: assert property (@(posedge core_clk) // [RULE14]
        disable iff (rst)
        !$past(rst) |-> cpu_irq[1] ==
            $past(|(irq_request[1][2:0] & s.irq_mask[1][2:0])))
        else $error("line 1 does not follow group 2 bits 2:0");

    a_irq0_source: assert property (@(posedge core_clk) // [RULE15]
        disable iff (rst)
        !$past(rst) |-> cpu_irq[0] ==
            $past(|({irq_request[3][1:0], irq_request[2][7:1],
                     bus_sys_reset} &
                    {s.irq_mask[3][1:0], s.irq_mask[2]})))
        else $error("line 0 does not follow groups 3 and 4");

    a_sysrst_readback: assert property (@(posedge core_clk) // [RULE20]
        disable iff (rst)
        (bus_rd && bus_addr == 12'h804) |=>
            bus_rdata[0] == $past(bus_sys_reset))
        else $error("bus system reset not seen in group 3 bit 0");

    a_slot_readback: assert property (@(posedge core_clk) // [RULE17]
        disable iff (rst)
        (bus_rd && bus_addr == 12'h807) |=>
            bus_rdata == {24'h0, $past(presence_detect[1])})
        else $error("slot 1 detect readback wrong");

    a_mask_clears_line: assert property (@(posedge core_clk) // [RULE22]
        disable iff (rst)
        (s.irq_mask == 32'h0) |=> cpu_irq == 4'h0)
        else $error("line raised while all requests masked");

    a_unmapped_zero: assert property (@(posedge core_clk) // [RULE1]
        disable iff (rst)
        (bus_rd && bus_addr == 12'h810) |=> bus_rdata == 32'h0)
        else $error("unmapped offset reads nonzero");

    a_upper_bits_zero: assert property (@(posedge core_clk) // [RULE21]
        disable iff (rst)
        bus_rdata[31:8] == 24'h0)
        else $error("upper data bits not zero");

    a_disp_hold: assert property (@(posedge core_clk) // [RULE2]
        disable iff (rst)
        !(bus_wr && bus_addr == OFF_DISPLAY) |=> $stable(s.disp))
        else $error("display register moved without write");

    a_bright_follow: assert property (@(posedge core_clk) // [RULE3]
        disable iff (rst)
        display_bright == $past(s.disp[DISP_BRIGHT_BIT]))
        else $error("brightness does not follow bit 7");

    a_dots_off: assert property (@(posedge core_clk) // [RULE6]
        !rst |=> !display_all_lit)
        else $error("dots still forced after reset");

    a_hb_pulse: assert property (@(posedge core_clk) // [RULE1]
        disable iff (rst)
        !$past(rst) |->
            heartbeat_clear == $past(bus_wr && bus_addr == OFF_HEARTBEAT))
        else $error("heartbeat clear pulse mismatch");

    a_rd_valid_pulse: assert property (@(posedge core_clk) // [RULE1]
        disable iff (rst)
        !$past(rst) |-> bus_rd_valid == $past(bus_rd))
        else $error("read valid does not follow read strobe");

    a_rdata_hold: assert property (@(posedge core_clk) // [RULE21]
        disable iff (rst)
        !bus_rd |=> $stable(bus_rdata))
        else $error("read data moved without read");

    a_grp1_readback: assert property (@(posedge core_clk) // [RULE12]
        disable iff (rst)
        (bus_rd && bus_addr == OFF_IRQ_MASK_1) |=>
            bus_rdata == {24'h0, $past(irq_request[IRQ_GRP_1])})
        else $error("group 1 request readback wrong");

    // per index: slot readback and mask storage
    for (genvar k = 0; k < 4; k++) begin : g_index_chk
        a_slot_value: assert property (@(posedge core_clk) // [RULE16]
            disable iff (rst)
            (bus_rd && bus_addr == OFF_MEM_SLOT_0 + bus_addr_t'(k)) |=>
                bus_rdata == {24'h0, $past(presence_detect[k])})
            else $error("slot detect readback wrong");

        a_mask_store: assert property (@(posedge core_clk) // [RULE22]
            disable iff (rst)
            (bus_wr && bus_addr == OFF_IRQ_MASK_1 + bus_addr_t'(k)) |=>
                s.irq_mask[k] == $past(bus_wdata[REG_W-1:0]))
            else $error("mask write not stored");
    end

    c_display_write: cover property (@(posedge core_clk) disable iff (rst)
        bus_wr && bus_addr == 12'h800 ##2 display_blank);
    c_timer_clear: cover property (@(posedge core_clk) disable iff (rst)
        rtc_timer_clear);
    c_line0_raised: cover property (@(posedge core_clk) disable iff (rst)
        cpu_irq[0] && bus_sys_reset);
    c_slot_read: cover property (@(posedge core_clk) disable iff (rst)
        bus_rd && bus_addr == 12'h809 ##1 bus_rd_valid);
    c_sysrst_read: cover property (@(posedge core_clk) disable iff (rst)
        bus_rd && bus_addr == OFF_IRQ_MASK_3 && bus_sys_reset);

endmodule : module_misc_register_bank

// ### tb/host_bus_model.sv
// host model driving the expansion bus register port
`timescale 1ns/1ps
module host_bus_model (
    input  wire logic                core_clk,
    output misc_regs_pkg::bus_addr_t bus_addr,
    output logic                     bus_rd,
    output logic                     bus_wr,
    output misc_regs_pkg::bus_data_t bus_wdata
);
    import misc_regs_pkg::*;
    initial begin
        bus_addr = '0;
        bus_rd = 1'b0;
        bus_wr = 1'b0;
        bus_wdata = '0;
    end
    // one strobe cycle; released lines flip so stale values never match
    task automatic access(input bus_addr_t a, input bus_data_t d,
                          input logic w);
        @(posedge core_clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_rd    <= !w;
        bus_wr    <= w;
        @(posedge core_clk);
        bus_rd    <= 1'b0;
        bus_wr    <= 1'b0;
        bus_addr  <= ~a;
        bus_wdata <= ~d;
    endtask : access
endmodule : host_bus_model

// ### tb/module_misc_register_bank_tb.sv
// self-checking bench for the board register bank
`timescale 1ns/1ps
module module_misc_register_bank_tb;
    import misc_regs_pkg::*;
    logic core_clk, rst, bus_rd, bus_wr, bus_rd_valid, boot_select_strap;
    logic bus_sys_reset, rtc_timer_clear, heartbeat_clear;
    logic display_bright, display_blank, display_all_lit;
    logic [1:0] io_module_type_code, processor_speed_code;
    logic [3:0] cpu_irq;
    logic [6:0] display_char;
    bus_addr_t bus_addr;
    bus_data_t bus_wdata, bus_rdata;
    pd_slots_t presence_detect;
    irq_vec_t irq_request;
    reg_byte_t mem_module_ident_bits, backup_cache_bits, board_control;
    int miscompares, check_count, cycles, g;
    bus_data_t exp_q[$], msk_q[$];
    logic [31:0] lfsr, req, msk, eff, live;
    logic sys;
    reg_byte_t c;

    host_bus_model i_host (.core_clk, .bus_addr, .bus_rd, .bus_wr,
                           .bus_wdata);
    module_misc_register_bank i_dut (.core_clk, .rst, .bus_addr, .bus_rd,
        .bus_wr, .bus_wdata, .bus_rdata, .bus_rd_valid, .boot_select_strap,
        .io_module_type_code, .processor_speed_code, .presence_detect,
        .mem_module_ident_bits, .backup_cache_bits, .irq_request,
        .bus_sys_reset, .cpu_irq, .rtc_timer_clear, .heartbeat_clear,
        .board_control, .display_char, .display_bright, .display_blank,
        .display_all_lit);

    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    function automatic void roll();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    endfunction : roll
    task automatic complete_run();
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    task automatic check(input bus_data_t seen, input bus_data_t exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rd(input bus_addr_t a, input bus_data_t e,
                      input bus_data_t m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        roll();
        i_host.access(a, lfsr, 1'b0);
    endtask : rd
    task automatic wr(input bus_addr_t a, input reg_byte_t d);
        roll();
        i_host.access(a, {lfsr[31:8], d}, 1'b1);
    endtask : wr
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : settle

    // read answers against the oldest note
    always @(negedge core_clk) begin
        if (bus_rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                miscompares++;
                $display("[ERR] %0t read answer without request", $time);
            end else begin
                check(bus_rdata & msk_q.pop_front(), exp_q.pop_front());
            end
        end
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            complete_run();
        end
    end

    initial begin
        lfsr = 32'hb2b34e3e;
        rst = 1'b1;
        boot_select_strap = 1'b0;
        io_module_type_code = 2'h0;
        processor_speed_code = 2'h0;
        presence_detect = '0;
        mem_module_ident_bits = 8'h00;
        backup_cache_bits = 8'h00;
        irq_request = '1;
        bus_sys_reset = 1'b1;
        settle(7);
        check(display_all_lit, 1'b1);
        @(posedge core_clk) rst <= 1'b0;
        settle(2);
        check({display_all_lit, display_bright, display_char}, 9'h0ff);
        check(cpu_irq, 4'h0);
        foreach (exp_q[i]) check(1'b1, 1'b0);
        for (int i = 0; i < 5; i++) begin
            c = (i == 0) ? 8'h57 : (i == 1) ? 8'hd7 : (i == 2) ? 8'h1f
              : (i == 3) ? 8'h20 : 8'h7f;
            wr(OFF_DISPLAY, c);
            settle(2);
            check(display_char, c[6:0]);
            check(display_bright, c[7]);
            check(display_blank, c[6:0] < 7'h20);
            rd(OFF_DISPLAY, c, '1);
        end
        for (int i = 0; i < 4; i++) begin
            roll();
            @(posedge core_clk);
            {io_module_type_code, boot_select_strap} <= lfsr[2:0];
            processor_speed_code <= lfsr[4:3];
            c = {1'b0, lfsr[4:0], 2'b0};
            rd(OFF_BOARD_CFG, c, 32'hffffff7c);
        end
        wr(OFF_BOARD_CFG, 8'h01);
        #1;
        check(rtc_timer_clear, 1'b1);
        settle(1);
        check(rtc_timer_clear, 1'b0);
        wr(OFF_BOARD_CFG, 8'hfe);
        #1;
        check(rtc_timer_clear, 1'b0);
        rd(OFF_BOARD_CFG, c, 32'hffffff7c);
        for (int p = 0; p < 2; p++) begin
            roll();
            msk = (p == 0) ? '1 : lfsr;
            for (int k = 0; k < 4; k++) wr(OFF_IRQ_MASK_1 + 12'(k), msk[8*k +: 8]);
            for (int i = 0; i < 33; i++) begin
                req = (i < 32) ? (32'h1 << i) : 32'h0;
                sys = (i == 32);
                @(posedge core_clk);
                irq_request <= req;
                bus_sys_reset <= sys;
                live = req;
                live[16] = sys;
                eff = live & msk;
                settle(2);
                check(cpu_irq, {|eff[3:0], |eff[5:4], |eff[10:8], |eff[25:16]});
                g = (i < 32) ? i / 8 : IRQ_GRP_3;
                rd(OFF_IRQ_MASK_1 + 12'(g), live[8*g +: 8], '1);
            end
        end
        roll();
        @(posedge core_clk);
        // slot nibbles carry the three documented module geometries
        presence_detect <= {lfsr[31:20], 4'b1011, lfsr[3:0], 4'b0101,
                            lfsr[7:4], 4'b0100};
        mem_module_ident_bits <= lfsr[7:0];
        backup_cache_bits <= lfsr[15:8];
        settle(1);
        for (int s = 0; s < 4; s++) rd(OFF_MEM_SLOT_0 + 12'(s), presence_detect[s], '1);
        wr(OFF_MEM_SLOT_0, ~presence_detect[0]);
        rd(OFF_MEM_SLOT_0, presence_detect[0], '1);
        rd(OFF_MEM_IDENT, mem_module_ident_bits, '1);
        rd(OFF_BCACHE_CFG, backup_cache_bits, '1);
        c = lfsr[23:16];
        wr(OFF_BOARD_CTRL, c);
        settle(1);
        check(board_control, c);
        rd(OFF_BOARD_CTRL, c, '1);
        wr(OFF_HEARTBEAT, 8'h00);
        #1;
        check(heartbeat_clear, 1'b1);
        rd(OFF_HEARTBEAT, 8'h00, '1);
        for (int k = 0; k < 3; k++) begin
            c = lfsr[8*k +: 8];
            wr((k == 0) ? OFF_RST_CAUSE_1 : (k == 1) ? OFF_RST_CAUSE_2
               : OFF_RST_CAUSE_3, c);
            rd((k == 0) ? OFF_RST_CAUSE_1 : (k == 1) ? OFF_RST_CAUSE_2
               : OFF_RST_CAUSE_3, c, '1);
        end
        rd(12'h810, 32'h0, '1);
        rd(12'h82d, 32'h0, '1);
        rd(12'h000, 32'h0, '1);
        @(posedge core_clk) rst <= 1'b1;
        settle(2);
        check(display_all_lit, 1'b1);
        @(posedge core_clk) rst <= 1'b0;
        settle(2);
        check({display_all_lit, display_bright, display_char}, 9'h0ff);
        check(board_control, 8'h00);
        rd(OFF_BOARD_CFG, {processor_speed_code, io_module_type_code,
           boot_select_strap, 2'b0}, 32'hffffff7c);
        settle(3);
        check(exp_q.size(), 0);
        complete_run();
    end
endmodule : module_misc_register_bank_tb
